// ==== hdl/ues_pkg.sv ====
package ues_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 8;
  localparam int          NUM_EP          = 16;
  localparam int          EP_W            = 4;
  localparam int          DEV_ADDR_W      = 7;
  localparam int          FRAME_W         = 11;
  localparam int          FRML_W          = 8;
  localparam int          FRMH_W          = 3;
  localparam int          RAM_AW          = 8;
  localparam int          STAT_DEPTH      = 4;
  localparam int          EPCTL_W         = 5;

  // register map of the core side
  localparam logic [11:0] ADDR_STATUS     = 12'h060;
  localparam logic [11:0] ADDR_FLAG       = 12'h061;
  localparam logic [11:0] ADDR_DEVADDR    = 12'h062;
  localparam logic [11:0] ADDR_FRML       = 12'h063;
  localparam logic [11:0] ADDR_FRMH       = 12'h064;
  localparam logic [11:0] ADDR_EPCTL_BASE = 12'h070;
  localparam logic [11:0] ADDR_EPCTL_LAST = 12'h07F;
  localparam logic [11:0] RAM_BASE        = 12'h400;
  localparam logic [11:0] RAM_LAST        = 12'h4FF;

  // endpoint control bit positions
  localparam int          EP_HSHK_BIT     = 4;
  localparam int          EP_CONDIS_BIT   = 3;
  localparam int          EP_OUTEN_BIT    = 2;
  localparam int          EP_INEN_BIT     = 1;
  localparam int          EP_STALL_BIT    = 0;
  localparam logic [4:0]  EPCTL_RESET     = 5'h00;

  // transfer status field positions
  localparam int          ST_ENDP_LSB     = 3;
  localparam int          ST_DIR_BIT      = 2;
  localparam int          ST_PINGPONG_BANK_INDICATOR_BIT     = 1;
  localparam int          FLAG_BIT        = 0;

  localparam logic [6:0]  DEVADDR_RESET   = 7'h00;

  // timing: re-raise of the completion flag
  localparam int          CLK_NS          = 100;
  localparam int          TCY_NS          = 83;
  localparam int          REASSERT_NS     = 6 * TCY_NS;
  localparam int          REASSERT_CYC    = (REASSERT_NS / CLK_NS < 1) ? 1 : REASSERT_NS / CLK_NS;

  typedef enum logic [1:0] {
    PID_OUT   = 2'h0,
    PID_IN    = 2'h1,
    PID_SETUP = 2'h2
  } ues_pid_t;

  typedef enum logic [3:0] {
    RESP_NONE = 4'h1,
    RESP_ACK  = 4'h2,
    RESP_NOHS = 4'h4,
    RESP_NAK  = 4'h8
  } ues_resp_code_t;

  typedef enum logic [2:0] {
    FL_EMPTY  = 3'h1,
    FL_RAISED = 3'h2,
    FL_HOLD   = 3'h4
  } ues_flag_state_t;

  typedef struct packed {
    ues_pid_t        pid;
    logic [6:0]      addr;
    logic [3:0]      endp;
  } ues_tok_t;

  typedef struct packed {
    logic [3:0]      endp;
    logic            dir;
    logic            pingpong_bank_indicator;
  } ues_done_t;

  typedef struct packed {
    ues_resp_code_t  code;
    logic [3:0]      endp;
    logic            desc_valid;
  } ues_resp_t;

endpackage

// ==== hdl/ues_dpram.sv ====
`timescale 1ns/1ps
module ues_dpram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [DW-1:0] a_wdata,
  input  wire logic          a_we,
  output logic      [DW-1:0] a_rdata,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [DW-1:0] b_wdata,
  input  wire logic          b_we,
  output logic      [DW-1:0] b_rdata
);

  // no reset on purpose: contents are unknown after any reset
  logic [DW-1:0] mem [2**AW];

  initial
  begin
    if (AW < 1 || DW < 1)
      $error("ues_dpram: bad geometry");
  end

  always_ff @(posedge clk_sys)
  begin
    if (a_we)
      mem[a_addr] <= a_wdata;
    if (b_we)
      mem[b_addr] <= b_wdata;
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule

// ==== hdl/ues_stat_fifo.sv ====
`timescale 1ns/1ps
module ues_stat_fifo #(
  parameter int DEPTH = 4
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire logic                    push,
  input  wire ues_pkg::ues_done_t      din,
  input  wire logic                    pop,
  output ues_pkg::ues_done_t           head,
  output logic                         full,
  output logic                         empty,
  output logic [$clog2(DEPTH+1)-1:0]   level
);
  import ues_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);

  ues_done_t         slot [DEPTH];
  logic [PW-1:0]     rd_ptr;
  logic [PW-1:0]     wr_ptr;
  logic [PW-1:0]     next_rd_ptr;
  logic [PW-1:0]     next_wr_ptr;
  logic [LW-1:0]     next_level;
  logic              do_push;
  logic              do_pop;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("ues_stat_fifo: depth must be a power of two");
  end

  assign full  = (level == LW'(DEPTH));
  assign empty = (level == '0);
  assign head  = slot[rd_ptr];

  always_comb
  begin
    do_push     = push && !full;
    do_pop      = pop && !empty;
    next_rd_ptr = do_pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
    next_wr_ptr = do_push ? PW'(wr_ptr + 1'b1) : wr_ptr;
    next_level  = level;
    if (do_push && !do_pop)
      next_level = LW'(level + 1'b1);
    else if (do_pop && !do_push)
      next_level = LW'(level - 1'b1);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      level  <= '0;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      level  <= next_level;
    end
  end

  // payload needs no reset; head shows slot[rd_ptr] even while the queue is empty
  always_ff @(posedge clk_sys)
  begin
    if (do_push)
      slot[wr_ptr] <= din;
  end

endmodule

// ==== hdl/ues_endpoint_status.sv ====
`timescale 1ns/1ps
module ues_endpoint_status #(
  parameter int NUM_EP     = 16,
  parameter int STAT_DEPTH = 4
) (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic [11:0]         reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic                sie_tok_valid,
  input  wire ues_pkg::ues_tok_t   sie_tok,
  input  wire logic                sie_done_valid,
  input  wire ues_pkg::ues_done_t  sie_done,
  input  wire logic                sie_stall_valid,
  input  wire logic [3:0]          sie_stall_endp,
  input  wire logic                sie_sof_valid,
  input  wire logic [10:0]         sie_sof_frame,
  input  wire logic                sie_bus_reset,
  input  wire logic [7:0]          sie_ram_addr,
  input  wire logic [7:0]          sie_ram_wdata,
  input  wire logic                sie_ram_we,
  output logic      [7:0]          sie_ram_rdata,
  output logic                     sie_resp_valid,
  output ues_pkg::ues_resp_t       sie_resp,
  output logic                     transfer_complete_flag
);
  import ues_pkg::*;

  localparam int LW = $clog2(STAT_DEPTH+1);

  initial
  begin
    if (NUM_EP < 1 || NUM_EP > 16)
      $error("ues_endpoint_status: NUM_EP must be 1..16");
    if (STAT_DEPTH != 4)
      $error("ues_endpoint_status: status queue depth is fixed at four");
  end

  function automatic logic is_epctl(input logic [11:0] a);
    is_epctl = (a >= ADDR_EPCTL_BASE) && (a <= ADDR_EPCTL_LAST)
               && (int'(a - ADDR_EPCTL_BASE) < NUM_EP);
  endfunction

  function automatic logic is_ram(input logic [11:0] a);
    is_ram = (a >= RAM_BASE) && (a <= RAM_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [4:0]       epctl        [NUM_EP];
  logic [4:0]       next_epctl   [NUM_EP];
  logic [6:0]       dev_addr;
  logic [6:0]       next_dev_addr;
  logic [10:0]      frame;
  logic [10:0]      next_frame;
  logic [7:0]       reg_q;
  logic [7:0]       next_reg_q;
  logic             rd_ram;
  logic             next_rd_ram;
  logic [7:0]       core_ram_q;
  logic [3:0]       ep_sel;
  ues_done_t        head;
  logic             q_full;
  logic             q_empty;
  logic [LW-1:0]    q_level;
  logic             pop;

  assign ep_sel = 4'(reg_addr - ADDR_EPCTL_BASE);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++)
    begin : g_ep
      always_comb
      begin
        next_epctl[gi] = epctl[gi];
        if (reg_wr && is_epctl(reg_addr) && ep_sel == 4'(gi))
          next_epctl[gi] = reg_wdata[4:0];
        // set wins over a firmware clear in the same cycle
        if (sie_stall_valid && sie_stall_endp == 4'(gi))
          next_epctl[gi][EP_STALL_BIT] = 1'b1;
      end

      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          epctl[gi] <= EPCTL_RESET;
        else
          epctl[gi] <= next_epctl[gi];
      end
    end
  endgenerate

  always_comb
  begin
    next_dev_addr = dev_addr;
    if (reg_wr && reg_addr == ADDR_DEVADDR)
      next_dev_addr = reg_wdata[6:0];
    if (sie_bus_reset)
      next_dev_addr = DEVADDR_RESET;
    next_frame = sie_sof_valid ? sie_sof_frame : frame;
    next_rd_ram = reg_rd && is_ram(reg_addr);
    next_reg_q  = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == ADDR_STATUS)
      begin
        // bits 7 and 0 stay zero
        next_reg_q[ST_ENDP_LSB +: EP_W] = head.endp;
        next_reg_q[ST_DIR_BIT]          = head.dir;
        next_reg_q[ST_PINGPONG_BANK_INDICATOR_BIT]         = head.pingpong_bank_indicator;
      end
      else if (reg_addr == ADDR_FLAG) next_reg_q[FLAG_BIT] = transfer_complete_flag;
      else if (reg_addr == ADDR_DEVADDR) next_reg_q[DEV_ADDR_W-1:0] = dev_addr;
      else if (reg_addr == ADDR_FRML) next_reg_q = frame[FRML_W-1:0];
      else if (reg_addr == ADDR_FRMH) next_reg_q[FRMH_W-1:0] = frame[FRAME_W-1:FRML_W];
      else if (is_epctl(reg_addr)) next_reg_q[EPCTL_W-1:0] = epctl[ep_sel];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dev_addr <= DEVADDR_RESET;
      frame    <= '0;
      reg_q    <= 8'h00;
      rd_ram   <= 1'b0;
    end
    else
    begin
      dev_addr <= next_dev_addr;
      frame    <= next_frame;
      reg_q    <= next_reg_q;
      rd_ram   <= next_rd_ram;
    end
  end

  // ram data already comes from its own register; only a select follows
  assign reg_rdata = rd_ram ? core_ram_q : reg_q;

  ////////////////////////////////////////////////////////////////////////////
  // shared buffer memory, descriptor table lives in it

  ues_dpram #(
    .AW (RAM_AW),
    .DW (DATA_W)
  ) u_ram (
    .clk_sys (clk_sys),
    .a_addr  (reg_addr[RAM_AW-1:0]),
    .a_wdata (reg_wdata),
    .a_we    (reg_wr && is_ram(reg_addr)),
    .a_rdata (core_ram_q),
    .b_addr  (sie_ram_addr),
    .b_wdata (sie_ram_wdata),
    .b_we    (sie_ram_we),
    .b_rdata (sie_ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status queue and completion flag

  ues_stat_fifo #(
    .DEPTH (STAT_DEPTH)
  ) u_queue (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .push    (sie_done_valid),
    .din     (sie_done),
    .pop     (pop),
    .head    (head),
    .full    (q_full),
    .empty   (q_empty),
    .level   (q_level)
  );

  ues_flag_state_t  fl_state;
  ues_flag_state_t  next_fl_state;
  logic             clear_req;

  assign clear_req = reg_wr && reg_addr == ADDR_FLAG && reg_wdata[FLAG_BIT];

  always_comb
  begin
    next_fl_state = fl_state;
    pop           = 1'b0;
    case (fl_state)
      FL_EMPTY:  if (!q_empty) next_fl_state = FL_RAISED;
      FL_RAISED:
        if (clear_req)
        begin
          pop           = 1'b1;
          next_fl_state = FL_HOLD;
        end
      FL_HOLD:
        // one low cycle so software sees the edge of the next entry
        next_fl_state = q_empty ? FL_EMPTY : FL_RAISED;
      default:   next_fl_state = FL_EMPTY;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      fl_state               <= FL_EMPTY;
      transfer_complete_flag <= 1'b0;
    end
    else
    begin
      fl_state               <= next_fl_state;
      transfer_complete_flag <= (next_fl_state == FL_RAISED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // token screening

  ues_resp_t        next_resp;
  logic             next_resp_valid;
  logic [4:0]       tok_ctl;
  logic             dir_ok;

  assign tok_ctl = epctl[sie_tok.endp];

  always_comb
  begin
    case (sie_tok.pid)
      PID_OUT:   dir_ok = tok_ctl[EP_OUTEN_BIT];
      PID_IN:    dir_ok = tok_ctl[EP_INEN_BIT];
      PID_SETUP:
        dir_ok = tok_ctl[EP_OUTEN_BIT]
                 && !(tok_ctl[EP_CONDIS_BIT] && tok_ctl[EP_INEN_BIT]);
      default:   dir_ok = 1'b0;
    endcase
    next_resp_valid       = sie_tok_valid && sie_tok.addr == dev_addr;
    next_resp.endp        = sie_tok.endp;
    next_resp.desc_valid  = tok_ctl[EP_INEN_BIT];
    if (!dir_ok || int'(sie_tok.endp) >= NUM_EP)
      next_resp.code = RESP_NONE;
    else if (q_full) next_resp.code = RESP_NAK;
    else if (tok_ctl[EP_HSHK_BIT]) next_resp.code = RESP_ACK;
    else next_resp.code = RESP_NOHS;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sie_resp_valid <= 1'b0;
      sie_resp       <= '{code: RESP_NONE, endp: 4'h0, desc_valid: 1'b0};
    end
    else
    begin
      sie_resp_valid <= next_resp_valid;
      sie_resp       <= next_resp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  localparam int FLAG_MAX = REASSERT_CYC;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_status_read;
    reg_rd && reg_addr == ADDR_STATUS && !q_empty
    |=> reg_rdata == {1'b0, $past(head.endp), $past(head.dir), $past(head.pingpong_bank_indicator), 1'b0};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read does not show the queue head");
  property p_unimpl_zero;
    reg_rd && is_epctl(reg_addr) |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented control bits read nonzero");
  property p_no_handshake;
    sie_tok_valid && sie_tok.addr == dev_addr && sie_tok.pid == PID_IN
    && tok_ctl[EP_INEN_BIT] && !tok_ctl[EP_HSHK_BIT] && !q_full
    |=> sie_resp_valid && sie_resp.code == RESP_NOHS;
  endproperty
  a_no_handshake: assert property (p_no_handshake)
    else $error("handshake sent on endpoint with handshakes off");
  property p_setup_refused;
    sie_tok_valid && sie_tok.pid == PID_SETUP && tok_ctl[EP_CONDIS_BIT]
    && tok_ctl[EP_INEN_BIT] && tok_ctl[EP_OUTEN_BIT]
    |=> sie_resp.code == RESP_NONE;
  endproperty
  a_setup_refused: assert property (p_setup_refused)
    else $error("setup accepted with control disabled");
  property p_out_disabled;
    sie_tok_valid && sie_tok.pid == PID_OUT && !tok_ctl[EP_OUTEN_BIT]
    |=> sie_resp.code == RESP_NONE;
  endproperty
  a_out_disabled: assert property (p_out_disabled)
    else $error("out accepted on disabled direction");
  property p_stall_sticky;
    sie_stall_valid |=> epctl[$past(sie_stall_endp)][EP_STALL_BIT] ##1
    (epctl[$past(sie_stall_endp, 2)][EP_STALL_BIT] || $past(reg_wr));
  endproperty
  a_stall_sticky: assert property (p_stall_sticky)
    else $error("stall indicator not held");
  property p_bus_reset_addr;
    sie_bus_reset |=> dev_addr == DEVADDR_RESET;
  endproperty
  a_bus_reset_addr: assert property (p_bus_reset_addr)
    else $error("address survived bus reset");
  property p_frame_capture;
    sie_sof_valid ##1 (reg_rd && reg_addr == ADDR_FRMH)
    |=> reg_rdata == {5'h00, $past(sie_sof_frame[FRAME_W-1:FRML_W], 2)};
  endproperty
  a_frame_capture: assert property (p_frame_capture)
    else $error("frame high bits not captured");
  property p_reraise;
    transfer_complete_flag && clear_req && q_level > LW'(1)
    |=> !transfer_complete_flag ##[1:FLAG_MAX] transfer_complete_flag;
  endproperty
  a_reraise: assert property (p_reraise)
    else $error("completion flag not raised again in time");
  property p_full_nak;
    sie_tok_valid && sie_tok.addr == dev_addr && q_full && dir_ok
    |=> sie_resp.code == RESP_NAK;
  endproperty
  a_full_nak: assert property (p_full_nak)
    else $error("full queue did not produce NAK");
  property p_addr_filter;
    sie_tok_valid && sie_tok.addr != dev_addr |=> !sie_resp_valid;
  endproperty
  a_addr_filter: assert property (p_addr_filter)
    else $error("answered a token for another device");
  c_nak: cover property (sie_resp_valid && sie_resp.code == RESP_NAK);
  c_reraise: cover property (fl_state == FL_HOLD ##1 fl_state == FL_RAISED);
  c_stall: cover property (sie_stall_valid ##1 reg_rd && is_epctl(reg_addr));

endmodule

// ==== verification/ues_host_model.sv ====
`timescale 1ns/1ps
module ues_host_model (
  input  wire logic               clk_sys,
  output logic                    tok_valid,
  output ues_pkg::ues_tok_t       tok,
  output logic                    done_valid,
  output ues_pkg::ues_done_t      done,
  output logic                    stall_valid,
  output logic [3:0]              stall_endp,
  output logic                    sof_valid,
  output logic [10:0]             sof_frame,
  output logic                    bus_reset,
  output logic [7:0]              ram_addr,
  output logic [7:0]              ram_wdata,
  output logic                    ram_we,
  input  wire logic [7:0]         ram_rdata
);
  import ues_pkg::*;
  initial
  begin
    {tok_valid, done_valid, stall_valid, sof_valid, bus_reset, ram_we} = '0;
    {tok, done, stall_endp, sof_frame, ram_addr, ram_wdata} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // released qualifiers flip so a stale value is never mistaken for a fresh one
  task automatic send_tok(input ues_pid_t p, input logic [6:0] a, input logic [3:0] e);
    @(posedge clk_sys);
    tok_valid <= 1'b1;
    tok       <= '{p, a, e};
    @(posedge clk_sys);
    tok_valid <= 1'b0;
    tok       <= ues_tok_t'(~tok);
  endtask
  task automatic push(input logic [3:0] e, input logic d, input logic pp);
    @(posedge clk_sys);
    done_valid <= 1'b1;
    done       <= '{e, d, pp};
    @(posedge clk_sys);
    done_valid <= 1'b0;
    done       <= ues_done_t'(~done);
  endtask
  task automatic stall(input logic [3:0] e);
    @(posedge clk_sys);
    stall_valid <= 1'b1;
    stall_endp  <= e;
    @(posedge clk_sys);
    stall_valid <= 1'b0;
    stall_endp  <= ~e;
  endtask
  task automatic sof(input logic [10:0] f);
    @(posedge clk_sys);
    sof_valid <= 1'b1;
    sof_frame <= f;
    @(posedge clk_sys);
    sof_valid <= 1'b0;
    sof_frame <= ~f;
  endtask
  task automatic breset();
    @(posedge clk_sys);
    bus_reset <= 1'b1;
    @(posedge clk_sys);
    bus_reset <= 1'b0;
  endtask
  // engine keeps to buffers it owns; the bench hands it free places only
  task automatic ram_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    ram_addr  <= a;
    ram_wdata <= d;
    ram_we    <= 1'b1;
    @(posedge clk_sys);
    ram_we    <= 1'b0;
    ram_wdata <= ~d;
  endtask
  task automatic ram_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    ram_addr <= a;
    @(posedge clk_sys);
    @(negedge clk_sys);
    d = ram_rdata;
  endtask
endmodule

// ==== verification/test_ues_endpoint_status.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_ues_endpoint_status;
  import ues_pkg::*;
  logic               clk_sys;
  logic               rstn;
  logic [11:0]        reg_addr;
  logic [7:0]         reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_rdata;
  logic               tok_valid, done_valid, stall_valid, sof_valid, bus_reset, ram_we;
  ues_tok_t           tok;
  ues_done_t          done;
  logic [3:0]         stall_endp;
  logic [10:0]        sof_frame;
  logic [7:0]         ram_addr, ram_wdata, ram_rdata, d;
  logic               resp_valid, flag;
  ues_resp_t          resp;
  int                 miscompares = 0;
  int                 cmp_count = 0;
  ues_endpoint_status u_ues_endpoint_status (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sie_tok_valid(tok_valid), .sie_tok(tok),
    .sie_done_valid(done_valid), .sie_done(done), .sie_stall_valid(stall_valid),
    .sie_stall_endp(stall_endp), .sie_sof_valid(sof_valid), .sie_sof_frame(sof_frame),
    .sie_bus_reset(bus_reset), .sie_ram_addr(ram_addr), .sie_ram_wdata(ram_wdata),
    .sie_ram_we(ram_we), .sie_ram_rdata(ram_rdata), .sie_resp_valid(resp_valid),
    .sie_resp(resp), .transfer_complete_flag(flag));
  ues_host_model u_ues_host_model (.clk_sys(clk_sys), .tok_valid(tok_valid), .tok(tok),
    .done_valid(done_valid), .done(done), .stall_valid(stall_valid),
    .stall_endp(stall_endp), .sof_valid(sof_valid), .sof_frame(sof_frame),
    .bus_reset(bus_reset), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
    .ram_rdata(ram_rdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    rd(a, d);
    `CHK("register", e, d)
  endtask
  // response is registered; a short bounded look covers it
  task automatic tok_chk(input ues_pid_t p, input logic [6:0] a, input logic [3:0] e,
                         input logic ev, input logic [3:0] ec, input logic ed = 1'b1);
    logic       seen;
    logic [3:0] code;
    logic [3:0] endp;
    logic       dv;
    seen = 1'b0;
    code = '0;
    endp = ~e;
    dv   = ~ed;
    fork
      u_ues_host_model.send_tok(p, a, e);
      repeat (3)
      begin
        @(negedge clk_sys);
        if (resp_valid === 1'b1)
        begin
          seen = 1'b1;
          code = resp.code;
          endp = resp.endp;
          dv   = resp.desc_valid;
        end
      end
    join
    `CHK("resp_valid", ev, seen)
    if (ev)
    begin
      `CHK("resp_code", ec, code)
      `CHK("resp_endp", e, endp)
      `CHK("desc_valid", ed, dv)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int n = 0; n < 16; n++)
      chk_rd(ADDR_EPCTL_BASE + n, 8'h00);
    chk_rd(ADDR_DEVADDR, 8'h00);
    for (int n = 0; n < 16; n++)
      wr(ADDR_EPCTL_BASE + n, {3'h7, n[3:0], 1'b0});
    for (int n = 0; n < 16; n++)
      chk_rd(ADDR_EPCTL_BASE + n, {3'h0, n[3:0], 1'b0});
    wr(12'h080, 8'hFF);
    chk_rd(12'h080, 8'h00);
  endtask
  task automatic t_tokens();
    wr(ADDR_DEVADDR, 8'h05);
    // descriptor set up before endpoints 0 to 4 are reconfigured; t_regs left most endpoints enabled
    wr(RAM_BASE + 12'h004, 8'h00);
    wr(ADDR_EPCTL_BASE, 8'h16);
    wr(ADDR_EPCTL_BASE + 1, 8'h16);
    wr(ADDR_EPCTL_BASE + 2, 8'h04);
    wr(ADDR_EPCTL_BASE + 3, 8'h06);
    wr(ADDR_EPCTL_BASE + 4, 8'h1E);
    tok_chk(PID_IN, 7'h05, 4'h1, 1'b1, RESP_ACK);
    tok_chk(PID_IN, 7'h05, 4'h2, 1'b1, RESP_NONE, 1'b0);
    tok_chk(PID_OUT, 7'h05, 4'h2, 1'b1, RESP_NOHS, 1'b0);
    tok_chk(PID_OUT, 7'h05, 4'h3, 1'b1, RESP_NOHS);
    tok_chk(PID_IN, 7'h05, 4'h3, 1'b1, RESP_NOHS);
    tok_chk(PID_OUT, 7'h05, 4'h5, 1'b1, RESP_NONE);
    tok_chk(PID_SETUP, 7'h05, 4'h4, 1'b1, RESP_NONE);
    tok_chk(PID_SETUP, 7'h05, 4'h0, 1'b1, RESP_ACK);
    tok_chk(PID_IN, 7'h06, 4'h1, 1'b0, RESP_NONE);
  endtask
  task automatic t_queue();
    logic [3:0] ep[4] = '{4'h1, 4'h2, 4'h3, 4'hF};
    logic [1:0] dp[4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    for (int i = 0; i < 4; i++)
      u_ues_host_model.push(ep[i], dp[i][1], dp[i][0]);
    tok_chk(PID_IN, 7'h05, 4'h1, 1'b1, RESP_NAK);
    for (int i = 0; i < 4; i++)
    begin
      repeat (REASSERT_CYC + 1)
        if (flag !== 1'b1)
          @(negedge clk_sys);
      `CHK("flag", 1'b1, flag)
      chk_rd(ADDR_STATUS, {1'b0, ep[i], dp[i], 1'b0});
      wr(ADDR_FLAG, 8'h01);
    end
    repeat (REASSERT_CYC + 1)
      @(negedge clk_sys);
    `CHK("flag", 1'b0, flag)
  endtask
  task automatic t_misc();
    u_ues_host_model.stall(4'h2);
    repeat (3)
      @(posedge clk_sys);
    chk_rd(ADDR_EPCTL_BASE + 2, 8'h05);
    chk_rd(ADDR_EPCTL_BASE + 2, 8'h05);
    wr(ADDR_EPCTL_BASE + 2, 8'h04);
    chk_rd(ADDR_EPCTL_BASE + 2, 8'h04);
    // read the high bits in the very cycle after the frame arrives
    fork
      u_ues_host_model.sof(11'h5A3);
      begin
        @(posedge clk_sys);
        chk_rd(ADDR_FRMH, 8'h05);
      end
    join
    wr(ADDR_FRML, 8'hFF);
    chk_rd(ADDR_FRML, 8'hA3);
    u_ues_host_model.breset();
    chk_rd(ADDR_DEVADDR, 8'h00);
    wr(RAM_BASE, 8'h3C);
    wr(RAM_LAST, 8'hC3);
    u_ues_host_model.ram_rd(8'h00, d);
    `CHK("ram", 8'h3C, d)
    u_ues_host_model.ram_rd(8'hFF, d);
    `CHK("ram", 8'hC3, d)
    u_ues_host_model.ram_wr(8'h04, 8'h5A);
    chk_rd(RAM_BASE + 12'h004, 8'h5A);
    chk_rd(12'h500, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #(100 * 8000);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    {rstn, reg_wr, reg_rd} = '0;
    reg_addr  = '0;
    reg_wdata = '0;
    repeat (16)
      @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_tokens();
    t_queue();
    t_misc();
    end_of_test();
  end
endmodule
